// ---- core/sepr_eeprom.sv ----
// Serial interface of a 64 x 16 nonvolatile memory: decoder on the link
// clock, self-timed programming and status on the system clock.
// Assumes the host keeps its own timing: start bit, data setup, CS low time.
//
// Behaviour
// [RL1] Start, 2-bit opcode, 6-bit word address
// [RL2] First one while selected is start
// [RL3] Decode read, write, erase, four special commands
// [RL4] Read: load word, dummy zero, sixteen bits
// [RL5] Output changes after rising serial clock edge
// [RL6] Output floats except read and status
// [RL7] Power-up disabled; enable until disable command
// [RL8] Reads work whether or not enabled
// [RL9] CS fall after erase starts timed erase
// [RL10] Status low while busy, high when ready
// [RL11] Host drops CS before next clock edge
// [RL12] Host holds CS low one microsecond
// [RL13] Host erases before writing
// [RL14] Erase-all sets every word to ones
// [RL15] Write-all stores pattern in every word
// [RL16] Serial clock may stop while programming
// [RL17] Programming voltage only during programming cycles
// [RL18] CS drop abandons partial instruction
`default_nettype none
`include "sepr_defs.svh"

module sepr_eeprom
  import sepr_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `SEPR_PROG_CYCLES
)(
  input wire logic mclk, // System clock, 50 MHz
  input wire logic sys_rst, // Reset, active high; synchronous except for the asynchronous held-command registers
  input wire logic clkEn, // Freezes system-clock state while low
  input wire logic chipSelect, // Chip select from host, active high
  input wire logic serialClockIn, // Serial clock from host
  input wire logic serialInput, // Serial data from host
  output logic serialOut, // Serial data or status to host
  output logic serialOutEn, // High while serialOut is driven
  output logic progVoltageOn // Programming voltage generator on
);

  localparam logic [19:0] PROG_LAST = 20'(PROG_CYCLES - 1);

  logic started_q, readMode_q, readOe_q, readBit_q, loaded_q, cmdReady_q;
  logic [4:0] bitCnt_q;
  sepr_opaddr_t opAddr_q, cmdOpAddr_q, nextOpAddr;
  sepr_word_t data_q, outShift_q, cmdData_q, memRd;
  logic lastAddr, readHit;

  assign nextOpAddr = {opAddr_q[6:0], serialInput};
  assign lastAddr = started_q && (bitCnt_q == `SEPR_LAST_ADDR_BIT);
  assign readHit = lastAddr && (nextOpAddr[7:6] == `SEPR_OP_READ);

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decoder on the link clock, cleared whenever CS is low
  always_ff @(posedge serialClockIn or negedge chipSelect) begin
    if (!chipSelect) begin
      started_q <= 1'b0; // RL18
      bitCnt_q <= 5'h00;
      opAddr_q <= 8'h00;
      data_q <= 16'h0000;
      readMode_q <= 1'b0;
    end else if (!started_q) begin
      if (serialInput) begin
        started_q <= 1'b1; // RL2
        bitCnt_q <= 5'h00;
      end
    end else if (bitCnt_q <= `SEPR_LAST_ADDR_BIT) begin
      opAddr_q <= nextOpAddr; // RL1
      bitCnt_q <= bitCnt_q + 5'h01;
      if (readHit) begin
        readMode_q <= 1'b1; // RL8
      end
    end else if (bitCnt_q != `SEPR_OVERRUN_BIT) begin
      bitCnt_q <= bitCnt_q + 5'h01;
      if (seprIsDataOp(opAddr_q)) begin
        data_q <= {data_q[14:0], serialInput};
      end
    end
  end

  // Read data path: dummy zero, then the word, MSB first
  always_ff @(posedge serialClockIn or negedge chipSelect) begin
    if (!chipSelect) begin
      readOe_q <= 1'b0; // RL6
      readBit_q <= 1'b0;
      loaded_q <= 1'b0;
      outShift_q <= 16'h0000;
    end else if (readHit) begin
      readOe_q <= 1'b1; // RL4
      readBit_q <= 1'b0; // RL4
    end else if (readMode_q && !loaded_q) begin
      readBit_q <= memRd[15]; // RL5
      outShift_q <= {memRd[14:0], 1'b0};
      loaded_q <= 1'b1;
    end else if (readMode_q) begin
      readBit_q <= outShift_q[15]; // RL5
      outShift_q <= {outShift_q[14:0], 1'b0};
    end
  end

  // Completed command held for the system clock; a new start bit retires it
  always_ff @(posedge serialClockIn or posedge sys_rst) begin
    if (sys_rst) begin
      cmdReady_q <= 1'b0;
      cmdOpAddr_q <= 8'h00;
      cmdData_q <= 16'h0000;
    end else if (chipSelect) begin
      if (!started_q && serialInput) begin
        cmdReady_q <= 1'b0;
      end else if (lastAddr && !seprIsDataOp(nextOpAddr) && !readHit) begin
        cmdReady_q <= 1'b1; // RL3
        cmdOpAddr_q <= nextOpAddr;
      end else if (started_q && (bitCnt_q == `SEPR_LAST_DATA_BIT) && seprIsDataOp(opAddr_q)) begin
        cmdReady_q <= 1'b1; // RL3
        cmdOpAddr_q <= opAddr_q;
        cmdData_q <= {data_q[14:0], serialInput};
      end else if (started_q && (bitCnt_q == `SEPR_OVERRUN_BIT) && seprIsDataOp(opAddr_q)) begin
        cmdReady_q <= 1'b0; // RL11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the system clock: three stages, change when last two agree
  logic [2:0] csSync_q, rdySync_q;
  logic csLvl_q, csPrev_q, rdyLvl_q, rdyPrev_q, csFell, rdyFell;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      csSync_q <= 3'h0;
      rdySync_q <= 3'h0;
    end else if (clkEn) begin
      csSync_q <= {csSync_q[1:0], chipSelect};
      rdySync_q <= {rdySync_q[1:0], cmdReady_q};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      csLvl_q <= 1'b0;
      csPrev_q <= 1'b0;
      rdyLvl_q <= 1'b0;
      rdyPrev_q <= 1'b0;
    end else if (clkEn) begin
      if (csSync_q[1] == csSync_q[2]) begin
        csLvl_q <= csSync_q[2];
      end
      if (rdySync_q[1] == rdySync_q[2]) begin
        rdyLvl_q <= rdySync_q[2];
      end
      csPrev_q <= csLvl_q;
      rdyPrev_q <= rdyLvl_q;
    end
  end

  assign csFell = csPrev_q && !csLvl_q;
  assign rdyFell = rdyPrev_q && !rdyLvl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Command launch on CS fall, programming enable
  sepr_state_e state_q;
  logic taken_q, progEn_q, launch, progStart, progEnd;
  logic [19:0] progCnt_q;

  assign launch = csFell && rdyLvl_q && !taken_q && (state_q == SEPR_IDLE);
  assign progStart = launch && progEn_q && seprIsProgOp(cmdOpAddr_q); // RL7
  assign progEnd = (state_q == SEPR_PROG) && (progCnt_q == PROG_LAST);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      taken_q <= 1'b0;
    end else if (clkEn) begin
      if (csFell && rdyLvl_q) begin
        taken_q <= 1'b1;
      end else if (rdyFell) begin
        taken_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      progEn_q <= 1'b0; // RL7
    end else if (clkEn && launch && (cmdOpAddr_q[7:6] == `SEPR_OP_SPECIAL)) begin
      if (cmdOpAddr_q[5:4] == `SEPR_SUB_ENABLE) begin
        progEn_q <= 1'b1; // RL7
      end else if (cmdOpAddr_q[5:4] == `SEPR_SUB_DISABLE) begin
        progEn_q <= 1'b0; // RL7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed programming cycle, independent of the serial clock
  logic wrEn_q, wrAll_q, wrErase_q, busy;
  sepr_addr_t wrAddr_q;
  sepr_word_t wrData_q;

  assign busy = (state_q == SEPR_PROG);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= SEPR_IDLE;
      progCnt_q <= 20'h00000;
    end else if (clkEn) begin
      case (state_q)
        SEPR_IDLE: begin
          progCnt_q <= 20'h00000;
          if (progStart) begin
            state_q <= SEPR_PROG; // RL9 RL16
          end
        end
        SEPR_PROG: begin
          progCnt_q <= progCnt_q + 20'h00001;
          if (progEnd) begin
            state_q <= SEPR_IDLE;
          end
        end
        default: begin
          state_q <= SEPR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrAll_q <= 1'b0;
      wrErase_q <= 1'b0;
      wrAddr_q <= 6'h00;
      wrData_q <= 16'h0000;
    end else if (clkEn && progStart) begin
      wrAll_q <= (cmdOpAddr_q[7:6] == `SEPR_OP_SPECIAL); // RL14 RL15
      wrErase_q <= (cmdOpAddr_q[7:6] == `SEPR_OP_ERASE) ||
                   ((cmdOpAddr_q[7:6] == `SEPR_OP_SPECIAL) && (cmdOpAddr_q[5:4] == `SEPR_SUB_ERASE_ALL));
      wrAddr_q <= cmdOpAddr_q[5:0];
      wrData_q <= cmdData_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrEn_q <= 1'b0;
      progVoltageOn <= 1'b0;
    end else if (clkEn) begin
      wrEn_q <= progEnd; // RL9
      progVoltageOn <= progStart || (busy && !progEnd); // RL17
    end
  end

  sepr_mem u_mem (
    .mclk(mclk), .sys_rst(sys_rst), .wrEn(wrEn_q && clkEn), .wrAll(wrAll_q), .wrErase(wrErase_q),
    .wrAddr(wrAddr_q), .wrData(wrData_q), .rdClk(serialClockIn), .rdEn(readHit),
    .rdAddr(nextOpAddr[5:0]), .rdData_q(memRd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ready/busy status while CS is high after a programming launch
  logic statusArm_q, statusOe_q, statusOut_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      statusArm_q <= 1'b0;
      statusOe_q <= 1'b0;
      statusOut_q <= 1'b0;
    end else if (clkEn) begin
      if (progStart) begin
        statusArm_q <= 1'b1;
      end else if (rdyFell) begin
        statusArm_q <= 1'b0;
      end
      statusOe_q <= statusArm_q && csLvl_q; // RL6
      statusOut_q <= !busy; // RL10
    end
  end

  // Two driving sources in different clock domains share the pin
  assign serialOut = statusOe_q ? statusOut_q : readBit_q;
  assign serialOutEn = statusOe_q || readOe_q; // RL6

  ////////////////////////////////////////////////////////////////////////////
  property p_hvOnlyProg;
    @(posedge mclk) disable iff (sys_rst) progVoltageOn |-> (state_q == SEPR_PROG);
  endproperty
  a_hvOnlyProg: assert property (p_hvOnlyProg) else $error("programming voltage outside a cycle"); // RL17
  property p_launchNeedsEnable;
    @(posedge mclk) disable iff (sys_rst) $rose(progVoltageOn) |-> $past(progEn_q) && $past(csFell);
  endproperty
  a_launchNeedsEnable: assert property (p_launchNeedsEnable) else $error("cycle began without enable or CS fall"); // RL7
  property p_resetDisabled;
    @(posedge mclk) disable iff (sys_rst) $past(sys_rst) |-> !progEn_q && !progVoltageOn;
  endproperty
  a_resetDisabled: assert property (p_resetDisabled) else $error("programming enabled after reset"); // RL7
  property p_writeAtEnd;
    @(posedge mclk) disable iff (sys_rst)
    (wrEn_q && clkEn) |-> !progVoltageOn && $past(progVoltageOn) && $past(progCnt_q) == PROG_LAST;
  endproperty
  a_writeAtEnd: assert property (p_writeAtEnd) else $error("cell write not at end of timed cycle"); // RL9
  property p_statusBusy;
    @(posedge mclk) disable iff (sys_rst) (busy && statusOe_q) |-> serialOutEn && !serialOut;
  endproperty
  a_statusBusy: assert property (p_statusBusy) else $error("status not low while busy"); // RL10
  property p_statusReady;
    @(posedge mclk) disable iff (sys_rst) (statusOe_q && !busy && $past(!busy)) |-> serialOut;
  endproperty
  a_statusReady: assert property (p_statusReady) else $error("status not high when ready"); // RL10
  // Status enable lags arm and CS by one cycle, so both are looked at one cycle back
  property p_oeCause;
    @(posedge mclk) disable iff (sys_rst) (serialOutEn && !readOe_q) |-> $past(statusArm_q && csLvl_q);
  endproperty
  a_oeCause: assert property (p_oeCause) else $error("output driven outside read or status"); // RL6
  property p_startBit;
    @(posedge serialClockIn) disable iff (!chipSelect) $rose(started_q) |-> $past(serialInput);
  endproperty
  a_startBit: assert property (p_startBit) else $error("start without a one on the input"); // RL2
  property p_dummy;
    @(posedge serialClockIn) disable iff (!chipSelect)
    $rose(readOe_q) |-> !readBit_q && $past(bitCnt_q) == `SEPR_LAST_ADDR_BIT;
  endproperty
  a_dummy: assert property (p_dummy) else $error("read did not open with dummy zero after address"); // RL4 RL1
  property p_firstData;
    @(posedge serialClockIn) disable iff (!chipSelect) $rose(readOe_q) |=> readBit_q == $past(memRd[15]);
  endproperty
  a_firstData: assert property (p_firstData) else $error("first data bit is not the word MSB"); // RL5

  c_read: cover property (@(posedge serialClockIn) disable iff (!chipSelect) $rose(readOe_q) ##1 readOe_q);
  c_prog: cover property (@(posedge mclk) disable iff (sys_rst) $rose(progVoltageOn));
  c_ready: cover property (@(posedge mclk) disable iff (sys_rst) statusOe_q && statusOut_q);
  c_enable: cover property (@(posedge mclk) disable iff (sys_rst) $rose(progEn_q));

endmodule : sepr_eeprom

`default_nettype wire

// ---- core/sepr_defs.svh ----
// Constants of the serial 64 x 16 nonvolatile memory interface.
// Assumes inclusion by its bare name from the package and the modules.
`ifndef SEPR_DEFS_SVH
`define SEPR_DEFS_SVH

`define SEPR_CLK_MHZ 50
`define SEPR_T_PROG_MS 10
`define SEPR_PROG_CYCLES (`SEPR_T_PROG_MS * `SEPR_CLK_MHZ * 1000)

`define SEPR_WORDS 64
`define SEPR_ADDR_W 6
`define SEPR_DATA_W 16
`define SEPR_ERASED 16'hffff

`define SEPR_OP_SPECIAL 2'h0
`define SEPR_OP_WRITE 2'h1
`define SEPR_OP_READ 2'h2
`define SEPR_OP_ERASE 2'h3

`define SEPR_SUB_DISABLE 2'h0
`define SEPR_SUB_WRITE_ALL 2'h1
`define SEPR_SUB_ERASE_ALL 2'h2
`define SEPR_SUB_ENABLE 2'h3

`define SEPR_LAST_ADDR_BIT 5'h07
`define SEPR_LAST_DATA_BIT 5'h17
`define SEPR_OVERRUN_BIT 5'h18

`endif

// ---- core/sepr_pkg.sv ----
// Types and decode helpers for the serial memory interface.
// Assumes sepr_defs.svh is on the include path.
`default_nettype none
`include "sepr_defs.svh"

package sepr_pkg;

  typedef enum logic [0:0] {
    SEPR_IDLE = 1'b0,
    SEPR_PROG = 1'b1
  } sepr_state_e;

  typedef logic [`SEPR_DATA_W-1:0] sepr_word_t;
  typedef logic [`SEPR_ADDR_W-1:0] sepr_addr_t;
  typedef logic [7:0] sepr_opaddr_t;

  // Instruction carries sixteen data bits after the address
  function automatic logic seprIsDataOp(input sepr_opaddr_t oa);
    seprIsDataOp = (oa[7:6] == `SEPR_OP_WRITE) ||
                   ((oa[7:6] == `SEPR_OP_SPECIAL) && (oa[5:4] == `SEPR_SUB_WRITE_ALL));
  endfunction : seprIsDataOp

  // Instruction needs the programming voltage
  function automatic logic seprIsProgOp(input sepr_opaddr_t oa);
    seprIsProgOp = (oa[7:6] == `SEPR_OP_WRITE) || (oa[7:6] == `SEPR_OP_ERASE) ||
                   ((oa[7:6] == `SEPR_OP_SPECIAL) &&
                    ((oa[5:4] == `SEPR_SUB_WRITE_ALL) || (oa[5:4] == `SEPR_SUB_ERASE_ALL)));
  endfunction : seprIsProgOp

endpackage : sepr_pkg

`default_nettype wire

// ---- core/sepr_mem.sv ----
// Cell array of 64 words of 16 bits, write port on the system clock,
// registered read port on the serial link clock.
// Assumes writes only happen while no read is in progress.
`default_nettype none
`include "sepr_defs.svh"

module sepr_mem
  import sepr_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic sys_rst, // System reset, only disables checks
  input wire logic wrEn, // Write strobe
  input wire logic wrAll, // Apply to every word
  input wire logic wrErase, // Set to ones instead of clearing bits
  input wire sepr_addr_t wrAddr, // Word to program
  input wire sepr_word_t wrData, // Pattern, only zeros take effect
  input wire logic rdClk, // Serial link clock
  input wire logic rdEn, // Read strobe
  input wire sepr_addr_t rdAddr, // Word to read
  output sepr_word_t rdData_q // Registered read data
);

  sepr_word_t mem_q [`SEPR_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // A write can only clear bits, so the host must erase first
  always_ff @(posedge mclk) begin
    for (int i = 0; i < `SEPR_WORDS; i++) begin
      if (wrEn && (wrAll || (wrAddr == sepr_addr_t'(i)))) begin
        mem_q[i] <= wrErase ? `SEPR_ERASED : (mem_q[i] & wrData);
      end
    end
  end

  always_ff @(posedge rdClk) begin
    if (rdEn) begin
      rdData_q <= mem_q[rdAddr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_eraseAll;
    @(posedge mclk) disable iff (sys_rst)
    (wrEn && wrAll && wrErase) |=> (mem_q[0] == `SEPR_ERASED) && (mem_q[63] == `SEPR_ERASED);
  endproperty
  a_eraseAll: assert property (p_eraseAll) else $error("erase-all left a word not all ones"); // RL14

  property p_writeAll;
    @(posedge mclk) disable iff (sys_rst)
    (wrEn && wrAll && !wrErase) |=> (mem_q[0] == ($past(mem_q[0]) & $past(wrData))) &&
                                    (mem_q[63] == ($past(mem_q[63]) & $past(wrData)));
  endproperty
  a_writeAll: assert property (p_writeAll) else $error("write-all missed a word"); // RL15

endmodule : sepr_mem

`default_nettype wire

// ---- sim/sepr_host_model.sv ----
// Host side of the three-wire serial link: selects the memory, clocks
// instruction and data bits in MSB first and samples the data/status pin.
// Assumes the caller keeps one transfer at a time; the link clock runs only in frames.
`default_nettype none

module sepr_host_model (
  output logic chipSelect, // Chip select to the memory
  output logic serialClockIn, // Link clock, still outside frames
  output logic serialInput, // Serial data to the memory
  input wire logic serialOut, // Data or status from the memory
  input wire logic serialOutEn // Memory drives serialOut
);
  timeunit 1ns;
  timeprecision 100ps;

  wire logic doLine;

  // Floating pin reads as high impedance so a missing drive never matches
  assign doLine = serialOutEn ? serialOut : 1'bz;

  initial begin
    chipSelect = 1'b0;
    serialClockIn = 1'b0;
    serialInput = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic csSet(input logic v);
    chipSelect = v;
  endtask : csSet

  // Shift n bits MSB first; rd collects the pin after the last 17 rising edges
  task automatic frame(input logic [31:0] bits, input int n, output logic [16:0] rd);
    rd = 17'h00000;
    chipSelect = 1'b1;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      serialInput = bits[i];
      #24;
      serialClockIn = 1'b1;
      #24;
      serialClockIn = 1'b0;
      rd = {rd[15:0], doLine};
    end
    serialInput = ~serialInput;
    #100;
    chipSelect = 1'b0;
    #1000;
  endtask : frame

endmodule : sepr_host_model

`default_nettype wire

// ---- sim/sepr_eeprom_tb_top.sv ----
// Self-checking bench of the serial 64 x 16 memory interface.
// Assumes sepr_pkg, sepr_defs.svh and the host model are compiled first.
`default_nettype none
`include "sepr_defs.svh"

module sepr_eeprom_tb_top;
  import sepr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned PROG = 200;
  localparam int LIMIT = 20000;

  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic clkEn = 1'b1;
  logic pvPrev = 1'b0;
  wire logic chipSelect;
  wire logic serialClockIn;
  wire logic serialInput;
  wire logic serialOut;
  wire logic serialOutEn;
  wire logic progVoltageOn;
  int mismatches = 0;
  int comparisons = 0;
  int pulses = 0;
  int highLen = 0;
  int cycles = 0;

  sepr_eeprom #(.PROG_CYCLES(PROG)) DUT (
    .mclk(mclk), .sys_rst(sysRst), .clkEn(clkEn), .chipSelect(chipSelect),
    .serialClockIn(serialClockIn), .serialInput(serialInput), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .progVoltageOn(progVoltageOn)
  );

  sepr_host_model host (
    .chipSelect(chipSelect), .serialClockIn(serialClockIn), .serialInput(serialInput),
    .serialOut(serialOut), .serialOutEn(serialOutEn)
  );

  always #10 mclk = ~mclk;

  // Counts programming pulses and the length of the latest one
  always @(posedge mclk) begin
    cycles++;
    if (progVoltageOn === 1'b1 && pvPrev !== 1'b1) begin
      pulses++;
      highLen = 1;
    end else if (progVoltageOn === 1'b1) begin
      highLen++;
    end
    pvPrev = progVoltageOn;
    if (cycles == LIMIT) begin
      mismatches++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic cmpRead(input string what, input logic [16:0] exp, input logic [16:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmpRead

  task automatic cmpBit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : cmpBit

  task automatic cmpCount(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmpCount

  //////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [1:0] op, input logic [5:0] addr);
    logic [16:0] rd;
    host.frame({23'h000000, 1'b1, op, addr}, 9, rd);
  endtask : send

  task automatic sendData(input logic [1:0] op, input logic [5:0] addr, input sepr_word_t d);
    logic [16:0] rd;
    host.frame({7'h00, 1'b1, op, addr, d}, 25, rd);
  endtask : sendData

  task automatic readWord(input string what, input logic [5:0] addr, input sepr_word_t exp);
    logic [16:0] rd;
    host.frame({7'h00, 1'b1, `SEPR_OP_READ, addr, 16'h0000}, 25, rd);
    cmpRead(what, {1'b0, exp}, rd);
    cmpBit("outReleased", 1'b0, serialOutEn);
  endtask : readWord

  task automatic checkStatus(input int expPulses);
    int n;
    host.csSet(1'b1);
    repeat (10) @(negedge mclk);
    cmpBit("statusEnable", 1'b1, serialOutEn);
    cmpBit("statusBusy", 1'b0, serialOut);
    cmpBit("progVoltageOn", 1'b1, progVoltageOn);
    n = 0;
    while (serialOut !== 1'b1 && n < 2 * PROG) begin
      @(negedge mclk);
      n++;
    end
    cmpBit("statusReady", 1'b1, serialOut);
    cmpBit("progVoltageOff", 1'b0, progVoltageOn);
    cmpCount("progPulses", expPulses, pulses);
    cmpCount("progLength", PROG, highLen);
    host.csSet(1'b0);
    #1000;
  endtask : checkStatus

  task automatic checkRefused(input string what, input int expPulses);
    host.csSet(1'b1);
    repeat (10) @(negedge mclk);
    cmpBit(what, 1'b0, serialOutEn);
    repeat (PROG) @(negedge mclk);
    cmpCount("progPulsesRefused", expPulses, pulses);
    host.csSet(1'b0);
    #1000;
  endtask : checkRefused

  //////////////////////////////////////////////////////////////////////////////
  task automatic tPowerUp;
    send(`SEPR_OP_ERASE, 6'h05);
    checkRefused("eraseWhileDisabled", 0);
    send(`SEPR_OP_SPECIAL, {`SEPR_SUB_ERASE_ALL, 4'h0});
    checkRefused("eraseAllWhileDisabled", 0);
  endtask : tPowerUp

  task automatic tEraseAll;
    send(`SEPR_OP_SPECIAL, {`SEPR_SUB_ENABLE, 4'h0});
    checkRefused("enableNoStatus", 0);
    send(`SEPR_OP_SPECIAL, {`SEPR_SUB_ERASE_ALL, 4'h0});
    checkStatus(1);
    readWord("eraseAllLow", 6'h00, `SEPR_ERASED);
    readWord("eraseAllHigh", 6'h3f, `SEPR_ERASED);
  endtask : tEraseAll

  task automatic tWrite;
    sendData(`SEPR_OP_WRITE, 6'h2a, 16'h5a3c);
    checkStatus(2);
    readWord("writeWord", 6'h2a, 16'h5a3c);
    readWord("writeNeighbourUp", 6'h2b, `SEPR_ERASED);
    readWord("writeNeighbourDown", 6'h29, `SEPR_ERASED);
  endtask : tWrite

  task automatic tLeadZeros;
    logic [16:0] rd;
    host.frame({7'h00, 1'b1, `SEPR_OP_READ, 6'h2a, 16'h0000}, 29, rd);
    cmpRead("leadingZerosRead", {1'b0, 16'h5a3c}, rd);
  endtask : tLeadZeros

  task automatic tAbort;
    logic [16:0] rd;
    host.frame({20'h00000, 1'b1, `SEPR_OP_WRITE, 6'h2a, 3'h0}, 12, rd);
    checkRefused("abortNoStatus", 2);
    readWord("abortKeepsWord", 6'h2a, 16'h5a3c);
  endtask : tAbort

  task automatic tWriteAll;
    send(`SEPR_OP_SPECIAL, {`SEPR_SUB_ERASE_ALL, 4'h0});
    checkStatus(3);
    sendData(`SEPR_OP_SPECIAL, {`SEPR_SUB_WRITE_ALL, 4'h0}, 16'hc3a5);
    checkStatus(4);
    readWord("writeAllLow", 6'h00, 16'hc3a5);
    readWord("writeAllHigh", 6'h3f, 16'hc3a5);
    send(`SEPR_OP_ERASE, 6'h11);
    checkStatus(5);
    readWord("eraseWord", 6'h11, `SEPR_ERASED);
    readWord("eraseNeighbour", 6'h10, 16'hc3a5);
  endtask : tWriteAll

  // Clock enable low in mid-cycle stretches the timed pulse by the frozen cycles
  task automatic tFreeze;
    send(`SEPR_OP_ERASE, 6'h12);
    @(negedge mclk);
    clkEn = 1'b0;
    repeat (50) @(negedge mclk);
    clkEn = 1'b1;
    repeat (PROG) @(negedge mclk);
    cmpCount("freezePulses", 6, pulses);
    cmpCount("freezeLength", PROG + 50, highLen);
    readWord("freezeErase", 6'h12, `SEPR_ERASED);
  endtask : tFreeze

  task automatic tDisable;
    send(`SEPR_OP_SPECIAL, {`SEPR_SUB_DISABLE, 4'h0});
    checkRefused("disableNoStatus", 6);
    send(`SEPR_OP_ERASE, 6'h10);
    checkRefused("eraseAfterDisable", 6);
    readWord("readWhileDisabled", 6'h10, 16'hc3a5);
  endtask : tDisable

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge mclk);
    sysRst = 1'b0;
    @(negedge mclk);
    #7;
    tPowerUp();
    tEraseAll();
    tWrite();
    tLeadZeros();
    tAbort();
    tWriteAll();
    tFreeze();
    tDisable();
    end_sim();
  end

endmodule : sepr_eeprom_tb_top

`default_nettype wire
